// file: rtl/ac_pkg.sv
// shared constants, types and register map for the comparator controller
package ac_pkg;
  // comparator and window pair counts
  localparam int NCOMP = 4;
  localparam int NPAIR = 2;

  // clock rates and sampling divider
  localparam int CORE_FREQ_HZ = 25_000_000;
  localparam int SAMPLE_FREQ_HZ = 1_000_000;
  localparam int SAMPLE_DIV_CYCLES = CORE_FREQ_HZ / SAMPLE_FREQ_HZ;
  localparam logic [4:0] SAMPLE_DIV_LAST = 5'(SAMPLE_DIV_CYCLES - 1);

  // start-up wait in sampling ticks, and the doubler's extra settling
  localparam logic [7:0] STARTUP_RESET = 8'h08;
  localparam logic [8:0] DOUBLER_EXTRA = 9'h004;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRLA = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_EVCTRL = 8'h08;
  localparam logic [7:0] ADDR_INTENSET = 8'h0C;
  localparam logic [7:0] ADDR_INTENCLR = 8'h10;
  localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  localparam logic [7:0] ADDR_READY = 8'h1C;
  localparam logic [7:0] ADDR_TRIGGER = 8'h20;
  localparam logic [7:0] ADDR_WINCTRL = 8'h24;
  localparam logic [7:0] ADDR_STARTUP = 8'h28;
  localparam logic [3:0] PAGE_COMPCTRL = 4'h3;
  localparam logic [3:0] PAGE_SCALER = 4'h4;

  // field positions
  localparam int CTRLA_ENABLE_BIT = 0;
  localparam int LOW_POWER_MUX_BIT = 1;
  localparam int CTRLA_WAKE_BIT = 2;
  localparam int EVCTRL_OUT_LSB = 8;
  localparam int WIN_FIELD_STRIDE = 4;
  localparam int STATE_WSTATE_LSB = 4;
  localparam int CC_ENABLE_BIT = 0;
  localparam int CC_SINGLE_BIT = 1;
  localparam int CC_INTSEL_LSB = 3;
  localparam int CC_MUXPOS_LSB = 8;
  localparam int CC_MUXNEG_LSB = 12;

  // negative input code that routes the supply-fraction scaler
  localparam logic [2:0] NEG_SCALER = 3'h5;

  // comparator interrupt select codes
  localparam logic [1:0] INTSEL_TOGGLE = 2'h0;
  localparam logic [1:0] INTSEL_RISE = 2'h1;
  localparam logic [1:0] INTSEL_FALL = 2'h2;
  localparam logic [1:0] INTSEL_EOC = 2'h3;

  // window state codes and window interrupt select codes
  localparam logic [1:0] WSTATE_ABOVE = 2'h0;
  localparam logic [1:0] WSTATE_INSIDE = 2'h1;
  localparam logic [1:0] WSTATE_BELOW = 2'h2;
  localparam logic [1:0] WINTSEL_ABOVE = 2'h0;
  localparam logic [1:0] WINTSEL_INSIDE = 2'h1;
  localparam logic [1:0] WINTSEL_BELOW = 2'h2;
  localparam logic [1:0] WINTSEL_OUTSIDE = 2'h3;

  // per-comparator control fields
  typedef struct packed {
    logic enable;
    logic single_shot_select;
    logic [1:0] interrupt_select;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
  } comp_cfg_s;

  // per-comparator analog front-end controls
  typedef struct packed {
    logic power;
    logic [2:0] pos_sel;
    logic [2:0] neg_sel;
    logic scaler_en;
    logic [5:0] scaler_level;
  } analog_ctrl_s;

  // register bus request from the master
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // per-comparator sequencer states, gray along off-wait-run
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_WAIT = 2'b01,
    CH_RUN = 2'b11,
    CH_IDLE = 2'b10
  } ch_state_e;
endpackage

// file: rtl/comp_channel.sv
// one comparator's sequencer: start-up wait, sampling and edge events
`timescale 1ns/1ps
module comp_channel
  import ac_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sampling enable and configuration
  input wire logic tick,
  input wire logic enable,
  input wire logic single,
  input wire logic [1:0] intsel,
  input wire logic [8:0] startup_len,
  // start request and synchronised comparator output
  input wire logic start,
  input wire logic sample,
  // status
  output logic result,
  output logic ready,
  output logic busy,
  output logic powered,
  output logic done,
  output logic int_evt
);
  // whole channel state
  typedef struct packed {
    ch_state_e st;
    logic [8:0] cnt;
    logic result;
    logic ready;
    logic done;
    logic int_evt;
  } ch_s;

  ch_s s_q; // registered state
  ch_s s_d; // next state

  // edge test between the new sample and the previous result
  function automatic logic edge_hit(input logic [1:0] sel, input logic nw,
                                    input logic old);
    case (sel)
      INTSEL_TOGGLE: edge_hit = nw != old;
      INTSEL_RISE: edge_hit = nw & ~old;
      INTSEL_FALL: edge_hit = ~nw & old;
      default: edge_hit = 1'b1; // end of comparison
    endcase
  endfunction

  // sequencer next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.int_evt = 1'b0;
    if (!enable) begin
      // disabled: comparator off, not ready
      s_d.st = CH_OFF;
      s_d.ready = 1'b0;
    end else begin
      case (s_q.st)
        CH_OFF: begin
          // load start-up wait; single-shot waits for a start
          s_d.cnt = startup_len;
          s_d.st = single ? CH_IDLE : CH_WAIT;
          s_d.ready = single;
        end
        CH_IDLE: begin
          // a start powers up and clears ready
          if (start) begin
            s_d.cnt = startup_len;
            s_d.ready = 1'b0;
            s_d.st = CH_WAIT;
          end
        end
        CH_WAIT: begin
          // starts are ignored while busy
          if (tick) begin
            if (s_q.cnt == 9'h000) begin
              s_d.result = sample;
              s_d.done = 1'b1;
              s_d.int_evt = edge_hit(intsel, sample, s_q.result);
              s_d.ready = 1'b1;
              s_d.st = single ? CH_IDLE : CH_RUN;
            end else begin
              s_d.cnt = s_q.cnt - 9'h001;
            end
          end
        end
        CH_RUN: begin
          // one compare per sampling tick, no further start-up wait
          if (tick) begin
            s_d.result = sample;
            s_d.done = 1'b1;
            s_d.int_evt = edge_hit(intsel, sample, s_q.result);
          end
          if (single) begin
            s_d.st = CH_IDLE;
          end
        end
        default: s_d.st = CH_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: CH_OFF, cnt: 9'h000, result: 1'b0, ready: 1'b0,
               done: 1'b0, int_evt: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // status outputs
  assign result = s_q.result;
  assign ready = s_q.ready;
  assign done = s_q.done;
  assign int_evt = s_q.int_evt;
  assign busy = s_q.st == CH_WAIT;
  assign powered = (s_q.st == CH_WAIT) || (s_q.st == CH_RUN);
endmodule

// file: rtl/comparator_sequencing_window.sv
// comparator controller: registers, starts, windows, events, clock request
`timescale 1ns/1ps
module comparator_sequencing_window (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire ac_pkg::bus_req_s bus_req,
  output logic [31:0] rdata,
  // comparator outputs from the analog side, asynchronous
  input wire logic [3:0] cmp_raw,
  // peripheral events in, one-cycle pulses on core_clk
  input wire logic [3:0] event_in,
  // power manager: sleep level on core_clk
  input wire logic sleep,
  // events out, interrupt and sampling clock request
  output logic [5:0] event_out,
  output logic irq,
  output logic clk_req,
  // analog front-end controls
  output logic doubler_en,
  output ac_pkg::analog_ctrl_s [3:0] analog_ctrl
);
  import ac_pkg::*;

  // whole controller state
  typedef struct packed {
    logic enable;
    logic lpmux;
    logic wake;
    comp_cfg_s [3:0] cfg;
    logic [7:0] startup;
    logic [3:0] evi_en;
    logic [5:0] evo_en;
    logic [5:0] inten;
    logic [5:0] flags;
    logic [1:0] wen;
    logic [1:0][1:0] wintsel;
    logic [1:0][1:0] wstate;
    logic [3:0][5:0] scaler;
    logic [3:0] raw1;
    logic [3:0] raw2;
    logic [4:0] div_cnt;
    logic [31:0] rdata;
    logic irq;
    logic [5:0] evout;
    logic clk_req;
    logic doubler;
    analog_ctrl_s [3:0] ana;
  } top_s;

  top_s s_q; // registered state
  top_s s_d; // next state

  // per-channel wires
  logic [3:0] ch_en; // channel enabled by both enables
  logic [3:0] ch_start; // start request this cycle
  logic [3:0] ch_result; // latest comparison result
  logic [3:0] ch_ready; // ready status
  logic [3:0] ch_busy; // in start-up wait
  logic [3:0] ch_powered; // analog comparator powered
  logic [3:0] ch_done; // one-cycle completion
  logic [3:0] ch_int; // one-cycle interrupt condition
  logic [8:0] startup_len; // wait including doubler settling
  logic tick; // sampling enable pulse
  logic clk_run; // sampling clock allowed to run
  logic [3:0] raw_start; // starts before window pairing
  logic [5:0] flag_set; // hardware flag sets
  logic [3:0] toggle; // continuous output differs from result

  // decoded bus strobes
  logic wr_hit;
  logic [3:0] cc_idx;
  assign wr_hit = bus_req.wr;
  assign cc_idx = {2'b00, bus_req.addr[3:2]};

  // the sampling clock runs while awake or while requested in sleep
  assign clk_run = ~sleep | s_q.clk_req;
  assign tick = clk_run && (s_q.div_cnt == SAMPLE_DIV_LAST);

  // doubler adds settling unless the low-power mux bit is set
  assign startup_len = {1'b0, s_q.startup} +
                       (s_q.lpmux ? 9'h000 : DOUBLER_EXTRA);

  // start sources: start bits, trigger read, input events
  always_comb begin
    for (int i = 0; i < NCOMP; i++) begin
      ch_en[i] = s_q.enable & s_q.cfg[i].enable;
      raw_start[i] = ch_en[i] & s_q.cfg[i].single_shot_select &
        ((wr_hit && bus_req.addr == ADDR_START && bus_req.wdata[i]) ||
         (bus_req.rd && bus_req.addr == ADDR_TRIGGER) ||
         (event_in[i] & s_q.evi_en[i]));
    end
    // a window pair launches both comparators together
    for (int p = 0; p < NPAIR; p++) begin
      if (s_q.wen[p]) begin
        ch_start[2*p] = raw_start[2*p] | raw_start[2*p+1];
        ch_start[2*p+1] = raw_start[2*p] | raw_start[2*p+1];
      end else begin
        ch_start[2*p] = raw_start[2*p];
        ch_start[2*p+1] = raw_start[2*p+1];
      end
    end
  end

  // one sequencer per comparator
  genvar g;
  generate
    for (g = 0; g < NCOMP; g++) begin : gen_ch
      comp_channel u_ch (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick),
        .enable(ch_en[g]),
        .single(s_q.cfg[g].single_shot_select),
        .intsel(s_q.cfg[g].interrupt_select),
        .startup_len(startup_len),
        .start(ch_start[g]),
        .sample(s_q.raw2[g]),
        .result(ch_result[g]),
        .ready(ch_ready[g]),
        .busy(ch_busy[g]),
        .powered(ch_powered[g]),
        .done(ch_done[g]),
        .int_evt(ch_int[g])
      );
    end
  endgenerate

  // window state from a pair's results
  function automatic logic [1:0] win_of(input logic a, input logic b);
    if (a & b) begin
      win_of = WSTATE_ABOVE;
    end else if (~a & ~b) begin
      win_of = WSTATE_BELOW;
    end else begin
      win_of = WSTATE_INSIDE;
    end
  endfunction

  // window interrupt condition for a state change
  function automatic logic win_hit(input logic [1:0] sel,
                                   input logic [1:0] old,
                                   input logic [1:0] nw);
    case (sel)
      WINTSEL_ABOVE: win_hit = nw == WSTATE_ABOVE;
      WINTSEL_INSIDE: win_hit = nw == WSTATE_INSIDE;
      WINTSEL_BELOW: win_hit = nw == WSTATE_BELOW;
      default: win_hit = old == WSTATE_INSIDE; // moved outside
    endcase
  endfunction

  // controller next state
  always_comb begin
    logic [1:0] nws;
    nws = WSTATE_ABOVE;
    s_d = s_q;
    flag_set = {2'b00, ch_int};

    // two-flop synchroniser on the comparator outputs
    s_d.raw1 = cmp_raw;
    s_d.raw2 = s_q.raw1;

    // sampling divider, held while the sampling clock is stopped
    if (clk_run) begin
      s_d.div_cnt = (s_q.div_cnt == SAMPLE_DIV_LAST) ? 5'h00 :
                    s_q.div_cnt + 5'h01;
    end

    // window state follows pair results whether or not interrupts are on
    for (int p = 0; p < NPAIR; p++) begin
      if (s_q.wen[p] && (ch_done[2*p] || ch_done[2*p+1])) begin
        nws = win_of(ch_result[2*p], ch_result[2*p+1]);
        s_d.wstate[p] = nws;
        if (nws != s_q.wstate[p] &&
            win_hit(s_q.wintsel[p], s_q.wstate[p], nws)) begin
          flag_set[4+p] = 1'b1;
        end
      end
    end

    // register writes
    if (wr_hit) begin
      case (bus_req.addr)
        ADDR_CTRLA: begin
          s_d.enable = bus_req.wdata[CTRLA_ENABLE_BIT];
          s_d.lpmux = bus_req.wdata[LOW_POWER_MUX_BIT];
          s_d.wake = bus_req.wdata[CTRLA_WAKE_BIT];
        end
        ADDR_EVCTRL: begin
          s_d.evi_en = bus_req.wdata[3:0];
          s_d.evo_en = bus_req.wdata[EVCTRL_OUT_LSB +: 6];
        end
        ADDR_INTENSET: s_d.inten = s_q.inten | bus_req.wdata[5:0];
        ADDR_INTENCLR: s_d.inten = s_q.inten & ~bus_req.wdata[5:0];
        ADDR_WINCTRL: begin
          for (int p = 0; p < NPAIR; p++) begin
            s_d.wen[p] = bus_req.wdata[WIN_FIELD_STRIDE*p];
            s_d.wintsel[p] = bus_req.wdata[WIN_FIELD_STRIDE*p+1 +: 2];
          end
        end
        ADDR_STARTUP: s_d.startup = bus_req.wdata[7:0];
        default: begin
          if (bus_req.addr[7:4] == PAGE_COMPCTRL) begin
            s_d.cfg[cc_idx[1:0]] = '{
              enable: bus_req.wdata[CC_ENABLE_BIT],
              single_shot_select: bus_req.wdata[CC_SINGLE_BIT],
              interrupt_select: bus_req.wdata[CC_INTSEL_LSB +: 2],
              positive_input_select: bus_req.wdata[CC_MUXPOS_LSB +: 3],
              negative_input_select: bus_req.wdata[CC_MUXNEG_LSB +: 3]};
          end else if (bus_req.addr[7:4] == PAGE_SCALER) begin
            s_d.scaler[cc_idx[1:0]] = bus_req.wdata[5:0];
          end
        end
      endcase
    end

    // flags: hardware set wins over a write-one clear
    if (wr_hit && bus_req.addr == ADDR_INTERRUPT_FLAGS) begin
      s_d.flags = (s_q.flags & ~bus_req.wdata[5:0]) | flag_set;
    end else begin
      s_d.flags = s_q.flags | flag_set;
    end

    // register reads, data stand one cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRLA: s_d.rdata[2:0] = {s_q.wake, s_q.lpmux, s_q.enable};
        ADDR_EVCTRL: begin
          s_d.rdata[3:0] = s_q.evi_en;
          s_d.rdata[EVCTRL_OUT_LSB +: 6] = s_q.evo_en;
        end
        ADDR_INTENSET: s_d.rdata[5:0] = s_q.inten;
        ADDR_INTENCLR: s_d.rdata[5:0] = s_q.inten;
        ADDR_INTERRUPT_FLAGS: s_d.rdata[5:0] = s_q.flags;
        ADDR_STATE: begin
          s_d.rdata[3:0] = ch_result;
          s_d.rdata[STATE_WSTATE_LSB +: 4] = s_q.wstate;
        end
        ADDR_READY: s_d.rdata[3:0] = ch_ready;
        ADDR_TRIGGER: s_d.rdata[3:0] = ch_ready & ~ch_busy;
        ADDR_WINCTRL: begin
          for (int p = 0; p < NPAIR; p++) begin
            s_d.rdata[WIN_FIELD_STRIDE*p] = s_q.wen[p];
            s_d.rdata[WIN_FIELD_STRIDE*p+1 +: 2] = s_q.wintsel[p];
          end
        end
        ADDR_STARTUP: s_d.rdata[7:0] = s_q.startup;
        default: begin
          if (bus_req.addr[7:4] == PAGE_COMPCTRL) begin
            s_d.rdata[CC_ENABLE_BIT] = s_q.cfg[cc_idx[1:0]].enable;
            s_d.rdata[CC_SINGLE_BIT] =
              s_q.cfg[cc_idx[1:0]].single_shot_select;
            s_d.rdata[CC_INTSEL_LSB +: 2] =
              s_q.cfg[cc_idx[1:0]].interrupt_select;
            s_d.rdata[CC_MUXPOS_LSB +: 3] =
              s_q.cfg[cc_idx[1:0]].positive_input_select;
            s_d.rdata[CC_MUXNEG_LSB +: 3] =
              s_q.cfg[cc_idx[1:0]].negative_input_select;
          end else if (bus_req.addr[7:4] == PAGE_SCALER) begin
            s_d.rdata[5:0] = s_q.scaler[cc_idx[1:0]];
          end
        end
      endcase
    end

    // combined interrupt request
    s_d.irq = |(s_q.flags & s_q.inten);

    // output events are level copies of comparator and window state
    s_d.evout[3:0] = s_q.evo_en[3:0] & ch_result;
    for (int p = 0; p < NPAIR; p++) begin
      s_d.evout[4+p] = s_q.evo_en[4+p] & s_q.wen[p] &
                       (s_q.wstate[p] == WSTATE_INSIDE);
    end

    // a continuous comparator whose output moved since its last sample
    for (int i = 0; i < NCOMP; i++) begin
      toggle[i] = ch_en[i] & ~s_q.cfg[i].single_shot_select &
                  (s_q.raw2[i] != ch_result[i]);
    end

    // in sleep the sampling clock is requested only while needed
    s_d.clk_req = sleep & ((|toggle) |
                           (|ch_busy) |
                           (s_q.wake & (|(s_q.flags & s_q.inten))));

    // analog controls: power, muxes, scaler and doubler
    for (int i = 0; i < NCOMP; i++) begin
      s_d.ana[i].power = ch_powered[i];
      s_d.ana[i].pos_sel = s_q.cfg[i].positive_input_select;
      s_d.ana[i].neg_sel = s_q.cfg[i].negative_input_select;
      s_d.ana[i].scaler_en = ch_en[i] &
        (s_q.cfg[i].negative_input_select == NEG_SCALER);
      s_d.ana[i].scaler_level = s_q.scaler[i];
    end
    s_d.doubler = ~s_q.lpmux & (|ch_powered);
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.startup <= STARTUP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign event_out = s_q.evout;
  assign clk_req = s_q.clk_req;
  assign doubler_en = s_q.doubler;
  assign analog_ctrl = s_q.ana;
endmodule

// file: testbench/comparator_sequencing_window_assertions.sv
// port-level checks for the comparator controller
`timescale 1ns/1ps
module comparator_sequencing_window_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire ac_pkg::bus_req_s bus_req,
  input wire logic [31:0] rdata,
  // analog, event and power inputs
  input wire logic [3:0] cmp_raw,
  input wire logic [3:0] event_in,
  input wire logic sleep,
  // outputs under watch
  input wire logic [5:0] event_out,
  input wire logic irq,
  input wire logic clk_req,
  input wire logic doubler_en,
  input wire ac_pkg::analog_ctrl_s [3:0] analog_ctrl
);
  import ac_pkg::*;
  // shadow of control bits as software last wrote them
  logic [2:0] ctrla_q;
  logic [5:0] evo_q;
  logic [1:0] cc0_q;

  // track writes so gating can be judged without the bodies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrla_q <= 3'h0;
      evo_q <= 6'h00;
      cc0_q <= 2'h0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_CTRLA) ctrla_q <= bus_req.wdata[2:0];
      if (bus_req.addr == ADDR_EVCTRL) evo_q <= bus_req.wdata[13:8];
      if (bus_req.addr == 8'h30) cc0_q <= bus_req.wdata[1:0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
    else $error("read data seen outside a read answer");
  a_start_reads_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == ADDR_START |-> rdata == 32'h0)
    else $error("start register read back nonzero");
  a_unmapped_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == 8'h2C |-> rdata == 32'h0)
    else $error("unmapped read nonzero");
  a_irq_masked: assert property (
    bus_req.wr && bus_req.addr == ADDR_INTENCLR && bus_req.wdata[5:0] == 6'h3F
    ##1 !(bus_req.wr && bus_req.addr == ADDR_INTENSET) |-> ##1 !irq)
    else $error("irq stays up with all enables cleared");
  a_doubler_lpmux: assert property (
    ctrla_q[1] && $past(ctrla_q[1]) && $past(ctrla_q[1], 2) |-> !doubler_en)
    else $error("doubler on with low power mux set");
  a_event_gate: assert property (
    (event_out & ~(evo_q | $past(evo_q))) == 6'h00)
    else $error("event output without its enable");
  a_start_clears_ready: assert property (
    bus_req.wr && bus_req.addr == ADDR_START && bus_req.wdata[0] &&
    cc0_q == 2'h3 && ctrla_q[0] ##2 bus_req.rd && bus_req.addr == ADDR_READY
    |-> ##1 !rdata[0])
    else $error("ready not cleared by start");
  // scaler reference only when the negative select picks it
  for (genvar i = 0; i < 4; i++) begin : g_sc
    a_scaler_code: assert property (
      analog_ctrl[i].scaler_en |-> analog_ctrl[i].neg_sel == NEG_SCALER)
      else $error("scaler enabled with another negative select");
  end
endmodule

bind comparator_sequencing_window comparator_sequencing_window_assertions
  u_chk (.core_clk, .rst, .bus_req, .rdata, .cmp_raw, .event_in, .sleep,
  .event_out, .irq, .clk_req, .doubler_en, .analog_ctrl);

// file: testbench/comparator_sequencing_window_tb_top.sv
// self-checking bench for the comparator controller
`timescale 1ns/1ps
module comparator_sequencing_window_tb_top;
  import ac_pkg::*;
  // one register row: address, value written, value read back
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_s;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_s bus_req = '0;
  logic [31:0] rdata;
  logic [3:0] cmp_raw = 4'h0;
  logic [3:0] event_in = 4'h0;
  logic sleep = 1'b0;
  logic [5:0] event_out;
  logic irq;
  logic clk_req;
  logic doubler_en;
  analog_ctrl_s [3:0] analog_ctrl;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] d;
  // register table cases
  row_s rows [13] = '{
    '{ADDR_STARTUP, 32'hFFFFFFFF, 32'h000000FF},
    '{ADDR_STARTUP, 32'h00000002, 32'h00000002},
    '{8'h2C, 32'hFFFFFFFF, 32'h00000000},
    '{ADDR_START, 32'h0000000F, 32'h00000000},
    '{ADDR_WINCTRL, 32'hFFFFFFFF, 32'h00000077},
    '{ADDR_WINCTRL, 32'h00000000, 32'h00000000},
    '{ADDR_EVCTRL, 32'hFFFFFFFF, 32'h00003F0F},
    '{ADDR_EVCTRL, 32'h00000000, 32'h00000000},
    '{8'h40, 32'hFFFFFFFF, 32'h0000003F},
    '{ADDR_INTENSET, 32'h0000003F, 32'h0000003F},
    '{ADDR_INTENCLR, 32'h0000003F, 32'h00000000},
    '{8'h30, 32'hFFFFFFFF, 32'h0000771B},
    '{8'h30, 32'h00000000, 32'h00000000}};

  comparator_sequencing_window dut (.core_clk, .rst, .bus_req, .rdata,
    .cmp_raw, .event_in, .sleep, .event_out, .irq, .clk_req, .doubler_en,
    .analog_ctrl);

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // poll ready of one comparator under a bound
  task automatic wait_ready(input int b);
    int n;
    n = 0;
    d = 32'h0;
    while (d[b] !== 1'b1 && n < 200) begin
      rd(ADDR_READY, d);
      n++;
    end
    chk("ready", 32'h1, {31'h0, d[b]});
  endtask

  task automatic pulse_evt(input int b);
    @(posedge core_clk);
    event_in[b] <= 1'b1;
    @(posedge core_clk);
    event_in <= 4'h0;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_STARTUP, d);
    chk("startup reset", 32'h8, d);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk("register", rows[i].e, d);
    end
    $display("register test done");
    // single shot, end of compare interrupt, scaler reference
    cmp_raw <= 4'h1;
    wr(ADDR_CTRLA, 32'h3);
    wr(8'h40, 32'h2A);
    wr(8'h30, 32'h501B);
    wr(ADDR_INTENSET, 32'h1);
    wr(ADDR_START, 32'h1);
    rd(ADDR_READY, d);
    chk("ready cleared", 32'h0, {31'h0, d[0]});
    chk("scaler on", 32'h1, {31'h0, analog_ctrl[0].scaler_en});
    chk("scaler level", 32'h2A, {26'h0, analog_ctrl[0].scaler_level});
    chk("doubler off", 32'h0, {31'h0, doubler_en});
    wait_ready(0);
    rd(ADDR_STATE, d);
    chk("single result", 32'h1, {31'h0, d[0]});
    chk("irq end", 32'h1, {31'h0, irq});
    wr(ADDR_INTERRUPT_FLAGS, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    cmp_raw <= 4'h0;
    repeat (150) @(posedge core_clk);
    rd(ADDR_STATE, d);
    chk("no rerun", 32'h1, {31'h0, d[0]});
    $display("single-shot test done");
    // start by status read, then again while busy
    rd(ADDR_TRIGGER, d);
    rd(ADDR_TRIGGER, d);
    chk("busy not ready", 32'h0, {31'h0, d[0]});
    wait_ready(0);
    rd(ADDR_STATE, d);
    chk("trigger result", 32'h0, {31'h0, d[0]});
    $display("trigger test done");
    // event start with falling edge select
    wr(8'h30, 32'h0);
    wr(8'h30, 32'h5013);
    wr(ADDR_EVCTRL, 32'h1);
    wr(ADDR_INTERRUPT_FLAGS, 32'h3F);
    cmp_raw <= 4'h1;
    pulse_evt(0);
    rd(ADDR_READY, d);
    chk("event clears ready", 32'h0, {31'h0, d[0]});
    wait_ready(0);
    rd(ADDR_INTERRUPT_FLAGS, d);
    chk("rise ignored", 32'h0, {31'h0, d[0]});
    cmp_raw <= 4'h0;
    pulse_evt(0);
    wait_ready(0);
    rd(ADDR_INTERRUPT_FLAGS, d);
    chk("fall flagged", 32'h1, {31'h0, d[0]});
    $display("event test done");
    // continuous on comparator one with doubler
    wr(ADDR_CTRLA, 32'h1);
    wr(ADDR_EVCTRL, 32'h200);
    wr(8'h34, 32'h1);
    wr(ADDR_INTERRUPT_FLAGS, 32'h3F);
    wait_ready(1);
    chk("doubler on", 32'h1, {31'h0, doubler_en});
    cmp_raw <= 4'h2;
    repeat (60) @(posedge core_clk);
    rd(ADDR_STATE, d);
    chk("follows high", 32'h1, {31'h0, d[1]});
    chk("event out", 32'h1, {31'h0, event_out[1]});
    rd(ADDR_INTERRUPT_FLAGS, d);
    chk("toggle flag", 32'h1, {31'h0, d[1]});
    cmp_raw <= 4'h0;
    repeat (60) @(posedge core_clk);
    rd(ADDR_STATE, d);
    chk("follows low", 32'h0, {31'h0, d[1]});
    $display("continuous test done");
    // window pair in single-shot, started through comparator zero only
    wr(8'h30, 32'h0);
    wr(8'h34, 32'h0);
    wr(8'h30, 32'h103);
    wr(8'h34, 32'h103);
    wr(ADDR_WINCTRL, 32'h3);
    wr(ADDR_EVCTRL, 32'h1000);
    wr(ADDR_INTERRUPT_FLAGS, 32'h3F);
    cmp_raw <= 4'h1;
    wr(ADDR_START, 32'h1);
    rd(ADDR_READY, d);
    chk("pair start", 32'h0, {31'h0, d[1]});
    wait_ready(1);
    rd(ADDR_STATE, d);
    chk("window inside", 32'h1, {30'h0, d[5:4]});
    rd(ADDR_INTERRUPT_FLAGS, d);
    chk("window flag", 32'h1, {31'h0, d[4]});
    chk("window event", 32'h1, {31'h0, event_out[4]});
    $display("window test done");
    complete_run();
  end
endmodule
